// ---- shared/comparator_pkg.sv ----
// Constants, register map and types of the comparator control block.
`default_nettype none

package comparator_pkg;

    // Register indices and their Avalon byte addresses.
    localparam logic [7:0] CONVERTER_CONTROL_B_INDEX = 8'h03;
    localparam logic [7:0] COMPARATOR_CONTROL_INDEX  = 8'h08;
    localparam logic [7:0] DIGITAL_INPUT_OFF_INDEX   = 8'h14;
    localparam logic [7:0] EVENT_STATUS_INDEX        = 8'h18;
    localparam logic [7:0] EVENT_CLEAR_INDEX         = 8'h19;
    localparam logic [7:0] EVENT_ENABLE_INDEX        = 8'h1a;

    localparam int         ADDR_W = 8;
    localparam int         DATA_W = 32;
    localparam int         BE_W   = 4;

    localparam logic [ADDR_W-1:0] CONVERTER_CONTROL_B_ADDR =
        {CONVERTER_CONTROL_B_INDEX[5:0], 2'b00};
    localparam logic [ADDR_W-1:0] COMPARATOR_CONTROL_ADDR  =
        {COMPARATOR_CONTROL_INDEX[5:0], 2'b00};
    localparam logic [ADDR_W-1:0] DIGITAL_INPUT_OFF_ADDR   =
        {DIGITAL_INPUT_OFF_INDEX[5:0], 2'b00};
    localparam logic [ADDR_W-1:0] EVENT_STATUS_ADDR        =
        {EVENT_STATUS_INDEX[5:0], 2'b00};
    localparam logic [ADDR_W-1:0] EVENT_CLEAR_ADDR         =
        {EVENT_CLEAR_INDEX[5:0], 2'b00};
    localparam logic [ADDR_W-1:0] EVENT_ENABLE_ADDR        =
        {EVENT_ENABLE_INDEX[5:0], 2'b00};

    // Converter control B fields.
    localparam int MUX_ENABLE_BIT  = 6;
    localparam int TRIGGER_W       = 3;

    // Comparator control and status fields.
    localparam int POWER_OFF_BIT   = 7;
    localparam int BANDGAP_BIT     = 6;
    localparam int RESULT_BIT      = 5;
    localparam int IRQ_FLAG_BIT    = 4;
    localparam int IRQ_ENABLE_BIT  = 3;
    localparam int MODE_LSB        = 0;
    localparam int MODE_W          = 2;

    // Digital input disable fields.
    localparam int BUFFER_OFF_W    = 6;
    localparam int POSITIVE_OFF_BIT = 0;
    localparam int NEGATIVE_OFF_BIT = 1;

    // Event status layout.
    localparam int STATUS_W        = 2;
    localparam int MATCH_EVENT_BIT = 0;
    localparam int TOGGLE_EVENT_BIT = 1;

    localparam int CHANNEL_W       = 2;
    localparam int SYNC_W          = 3;
    localparam int SYNC_RESULT     = 0;
    localparam int SYNC_POSITIVE   = 1;
    localparam int SYNC_NEGATIVE   = 2;

    typedef enum logic [1:0] {
        MODE_TOGGLE   = 2'b00,
        MODE_RESERVED = 2'b01,
        MODE_FALLING  = 2'b10,
        MODE_RISING   = 2'b11
    } irq_mode_t;

    typedef enum logic [2:0] {
        SEL_NONE      = 3'b000,
        SEL_CONV_B    = 3'b001,
        SEL_CONTROL   = 3'b010,
        SEL_INPUT_OFF = 3'b011,
        SEL_STATUS    = 3'b100,
        SEL_CLEAR     = 3'b101,
        SEL_ENABLE    = 3'b110
    } reg_sel_t;

endpackage : comparator_pkg

`default_nettype wire

// ---- rtl/signal_sync.sv ----
// Two-stage synchroniser for asynchronous level inputs.
`default_nettype none

module signal_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset.
    input  wire logic             clk,
    input  wire logic             reset,
    // Levels.
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } sync_state_t;

    sync_state_t st;
    sync_state_t next_st;

    always_comb begin
        next_st        = st;
        next_st.first  = async_in;
        next_st.second = st.first;
    end

    // The stages keep sampling through reset, so that the level is settled
    // when reset ends and no false edge follows it.
    always_ff @(posedge clk) begin
        st <= next_st;
    end

    assign sync_out = st.second;

endmodule : signal_sync

`default_nettype wire

// ---- rtl/analog_comparator_control.sv ----
// Register, synchronisation and event logic around the analog comparator.
`default_nettype none

module analog_comparator_control (
    // Clock and reset.
    input  wire logic                                clk,
    input  wire logic                                reset,
    // Avalon-MM slave.
    input  wire logic [comparator_pkg::ADDR_W-1:0]   avs_address,
    input  wire logic                                avs_read,
    input  wire logic                                avs_write,
    input  wire logic [comparator_pkg::DATA_W-1:0]   avs_writedata,
    input  wire logic [comparator_pkg::BE_W-1:0]     avs_byteenable,
    output logic      [comparator_pkg::DATA_W-1:0]   avs_readdata,
    output logic                                     avs_waitrequest,
    // Analog side.
    input  wire logic                                comparator_raw,
    input  wire logic                                positive_pin_level,
    input  wire logic                                negative_pin_level,
    output logic                                     comparator_power_off,
    output logic                                     bandgap_select,
    output logic                                     negative_from_mux,
    output logic      [comparator_pkg::CHANNEL_W-1:0] negative_channel,
    output logic      [comparator_pkg::BUFFER_OFF_W-1:0] input_buffer_off,
    output logic                                     positive_pin_read,
    output logic                                     negative_pin_read,
    // Converter and processor side.
    input  wire logic                                converter_enable,
    input  wire logic [comparator_pkg::CHANNEL_W-1:0] channel_select,
    input  wire logic                                global_irq_enable,
    input  wire logic                                irq_vector_taken,
    output logic      [comparator_pkg::TRIGGER_W-1:0] trigger_source_select,
    output logic                                     irq_request,
    output logic                                     irq
);

    typedef struct packed {
        logic                                     mux_enable;
        logic [comparator_pkg::TRIGGER_W-1:0]     trigger;
        logic                                     power_off;
        logic                                     bandgap;
        logic                                     flag;
        logic                                     irq_enable;
        comparator_pkg::irq_mode_t                mode;
        logic [comparator_pkg::BUFFER_OFF_W-1:0]  buffer_off;
        logic                                     result_prev;
        logic [comparator_pkg::STATUS_W-1:0]      status;
        logic [comparator_pkg::STATUS_W-1:0]      status_enable;
        logic                                     waitrequest;
        logic [comparator_pkg::DATA_W-1:0]        readdata;
        logic                                     neg_from_mux;
        logic [comparator_pkg::CHANNEL_W-1:0]     neg_channel;
        logic                                     pos_read;
        logic                                     neg_read;
        logic                                     irq_request;
        logic                                     irq;
    } state_t;

    function automatic comparator_pkg::reg_sel_t decode(
        input logic [comparator_pkg::ADDR_W-1:0] addr
    );
        comparator_pkg::reg_sel_t sel;
        sel = comparator_pkg::SEL_NONE;
        if (addr == comparator_pkg::CONVERTER_CONTROL_B_ADDR) begin
            sel = comparator_pkg::SEL_CONV_B;
        end else if (addr == comparator_pkg::COMPARATOR_CONTROL_ADDR) begin
            sel = comparator_pkg::SEL_CONTROL;
        end else if (addr == comparator_pkg::DIGITAL_INPUT_OFF_ADDR) begin
            sel = comparator_pkg::SEL_INPUT_OFF;
        end else if (addr == comparator_pkg::EVENT_STATUS_ADDR) begin
            sel = comparator_pkg::SEL_STATUS;
        end else if (addr == comparator_pkg::EVENT_CLEAR_ADDR) begin
            sel = comparator_pkg::SEL_CLEAR;
        end else if (addr == comparator_pkg::EVENT_ENABLE_ADDR) begin
            sel = comparator_pkg::SEL_ENABLE;
        end
        return sel;
    endfunction : decode

    state_t                             st;
    state_t                             next_st;
    logic [comparator_pkg::SYNC_W-1:0]  synced;
    logic                               result;
    logic                               changed;
    logic                               match;
    logic                               request;
    logic                               commit;
    logic                               write_low;
    logic                               flag_clear;
    logic [comparator_pkg::STATUS_W-1:0] events;
    logic [comparator_pkg::STATUS_W-1:0] status_clear;
    logic [7:0]                         wbyte;
    logic [7:0]                         rbyte;
    comparator_pkg::reg_sel_t           sel;

    // The analog result and both pin levels are resynchronised here.
    signal_sync #(
        .WIDTH (comparator_pkg::SYNC_W)
    ) u_sync (
        .clk      (clk),
        .reset    (reset),
        .async_in ({negative_pin_level, positive_pin_level, comparator_raw}),
        .sync_out (synced)
    );

    always_comb begin
        next_st      = st;
        result       = synced[comparator_pkg::SYNC_RESULT];
        sel          = decode(avs_address);
        wbyte        = avs_writedata[7:0];
        request      = avs_read || avs_write;
        commit       = request && !st.waitrequest;
        write_low    = avs_write && commit && avs_byteenable[0];

        // Events come from comparing the result with its last value.
        changed      = result != st.result_prev;
        next_st.result_prev = result;
        unique case (st.mode)
            comparator_pkg::MODE_TOGGLE:   match = changed;
            comparator_pkg::MODE_RESERVED: match = 1'b0;
            comparator_pkg::MODE_FALLING:  match = changed && !result;
            comparator_pkg::MODE_RISING:   match = changed && result;
        endcase

        // Register writes take effect on the committing edge.
        flag_clear   = irq_vector_taken;
        status_clear = '0;
        if (write_low) begin
            unique case (sel)
                comparator_pkg::SEL_CONV_B: begin
                    next_st.mux_enable =
                        wbyte[comparator_pkg::MUX_ENABLE_BIT];
                    next_st.trigger =
                        wbyte[comparator_pkg::TRIGGER_W-1:0];
                end
                comparator_pkg::SEL_CONTROL: begin
                    next_st.power_off =
                        wbyte[comparator_pkg::POWER_OFF_BIT];
                    next_st.bandgap =
                        wbyte[comparator_pkg::BANDGAP_BIT];
                    next_st.irq_enable =
                        wbyte[comparator_pkg::IRQ_ENABLE_BIT];
                    next_st.mode = comparator_pkg::irq_mode_t'(
                        wbyte[comparator_pkg::MODE_LSB +:
                              comparator_pkg::MODE_W]);
                    if (wbyte[comparator_pkg::IRQ_FLAG_BIT]) begin
                        flag_clear = 1'b1;
                    end
                end
                comparator_pkg::SEL_INPUT_OFF: begin
                    next_st.buffer_off =
                        wbyte[comparator_pkg::BUFFER_OFF_W-1:0];
                end
                comparator_pkg::SEL_CLEAR: begin
                    status_clear = wbyte[comparator_pkg::STATUS_W-1:0];
                end
                comparator_pkg::SEL_ENABLE: begin
                    next_st.status_enable =
                        wbyte[comparator_pkg::STATUS_W-1:0];
                end
                default: begin
                end
            endcase
        end

        // A new event wins over a clear in the same cycle.
        next_st.flag = match || (st.flag && !flag_clear);
        events = '0;
        events[comparator_pkg::MATCH_EVENT_BIT]  = match;
        events[comparator_pkg::TOGGLE_EVENT_BIT] = changed;
        next_st.status = events | (st.status & ~status_clear);
        next_st.irq    = |(st.status & st.status_enable);
        next_st.irq_request =
            st.flag && st.irq_enable && global_irq_enable;

        // Negative input selection and pin reads.
        next_st.neg_from_mux = st.mux_enable && !converter_enable;
        next_st.neg_channel  = channel_select;
        next_st.pos_read = synced[comparator_pkg::SYNC_POSITIVE] &&
            !st.buffer_off[comparator_pkg::POSITIVE_OFF_BIT];
        next_st.neg_read = synced[comparator_pkg::SYNC_NEGATIVE] &&
            !st.buffer_off[comparator_pkg::NEGATIVE_OFF_BIT];

        // Read data is latched on the same edge that drops waitrequest.
        rbyte = '0;
        unique case (sel)
            comparator_pkg::SEL_CONV_B: begin
                rbyte[comparator_pkg::MUX_ENABLE_BIT] = st.mux_enable;
                rbyte[comparator_pkg::TRIGGER_W-1:0]  = st.trigger;
            end
            comparator_pkg::SEL_CONTROL: begin
                // Bit 2 is left at zero.
                rbyte[comparator_pkg::POWER_OFF_BIT]  = st.power_off;
                rbyte[comparator_pkg::BANDGAP_BIT]    = st.bandgap;
                rbyte[comparator_pkg::RESULT_BIT]     = result;
                rbyte[comparator_pkg::IRQ_FLAG_BIT]   = st.flag;
                rbyte[comparator_pkg::IRQ_ENABLE_BIT] = st.irq_enable;
                rbyte[comparator_pkg::MODE_LSB +: comparator_pkg::MODE_W] =
                    st.mode;
            end
            comparator_pkg::SEL_INPUT_OFF: begin
                rbyte[comparator_pkg::BUFFER_OFF_W-1:0] = st.buffer_off;
            end
            comparator_pkg::SEL_STATUS: begin
                rbyte[comparator_pkg::STATUS_W-1:0] = st.status;
            end
            comparator_pkg::SEL_ENABLE: begin
                rbyte[comparator_pkg::STATUS_W-1:0] = st.status_enable;
            end
            default: begin
            end
        endcase
        if (avs_read && st.waitrequest) begin
            next_st.readdata = {24'h00_0000, rbyte};
        end
        next_st.waitrequest = !(request && st.waitrequest);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st             <= '0;
            st.waitrequest <= 1'b1;
            st.result_prev <= synced[comparator_pkg::SYNC_RESULT];
        end else begin
            st <= next_st;
        end
    end

    assign avs_readdata          = st.readdata;
    assign avs_waitrequest       = st.waitrequest;
    assign comparator_power_off  = st.power_off;
    assign bandgap_select        = st.bandgap;
    assign negative_from_mux     = st.neg_from_mux;
    assign negative_channel      = st.neg_channel;
    assign input_buffer_off      = st.buffer_off;
    assign positive_pin_read     = st.pos_read;
    assign negative_pin_read     = st.neg_read;
    assign trigger_source_select = st.trigger;
    assign irq_request           = st.irq_request;
    assign irq                   = st.irq;

    default clocking @(posedge clk);
    endclocking
    default disable iff (reset);

    property p_result_lag;
        $past(!reset, 3) |-> result == $past(comparator_raw, 2);
    endproperty
    a_result_lag: assert property (p_result_lag)
        else $error("Result does not follow raw output after two clocks.");

    property p_negative_mux;
        $past(!reset) |-> negative_from_mux ==
            ($past(st.mux_enable) && !$past(converter_enable));
    endproperty
    a_negative_mux: assert property (p_negative_mux)
        else $error("Negative input selection is wrong.");

    property p_bandgap;
        write_low && sel == comparator_pkg::SEL_CONTROL |=>
            bandgap_select == $past(wbyte[comparator_pkg::BANDGAP_BIT]);
    endproperty
    a_bandgap: assert property (p_bandgap)
        else $error("Bandgap select did not take the written value.");

    property p_toggle_sets;
        st.mode == comparator_pkg::MODE_TOGGLE && changed |=> st.flag;
    endproperty
    a_toggle_sets: assert property (p_toggle_sets)
        else $error("Toggle event did not set the flag.");

    property p_edge_mode;
        st.mode == comparator_pkg::MODE_RISING && changed && !result &&
            !st.flag && !irq_vector_taken |=> !st.flag;
    endproperty
    a_edge_mode: assert property (p_edge_mode)
        else $error("Falling edge set the flag in rising mode.");

    property p_reserved_mode;
        st.mode == comparator_pkg::MODE_RESERVED && !st.flag |=> !st.flag;
    endproperty
    a_reserved_mode: assert property (p_reserved_mode)
        else $error("Reserved mode set the flag.");

    property p_irq_request;
        $past(!reset) |-> irq_request ==
            ($past(st.flag) && $past(st.irq_enable) &&
             $past(global_irq_enable));
    endproperty
    a_irq_request: assert property (p_irq_request)
        else $error("Interrupt request does not match its three terms.");

    property p_vector_clear;
        irq_vector_taken && !match |=> !st.flag;
    endproperty
    a_vector_clear: assert property (p_vector_clear)
        else $error("Vector did not clear the flag.");

    property p_write_one_clear;
        write_low && sel == comparator_pkg::SEL_CONTROL && !match &&
            wbyte[comparator_pkg::IRQ_FLAG_BIT] |=> !st.flag;
    endproperty
    a_write_one_clear: assert property (p_write_one_clear)
        else $error("Writing one did not clear the flag.");

    property p_pin_zero;
        st.buffer_off[comparator_pkg::POSITIVE_OFF_BIT] |=>
            !positive_pin_read;
    endproperty
    a_pin_zero: assert property (p_pin_zero)
        else $error("Disabled positive pin did not read zero.");

    property p_reserved_bit;
        avs_read && st.waitrequest && sel == comparator_pkg::SEL_CONTROL
            |=> avs_readdata[2] == 1'b0;
    endproperty
    a_reserved_bit: assert property (p_reserved_bit)
        else $error("Reserved control bit read as one.");

endmodule : analog_comparator_control

`default_nettype wire

// ---- verif/analog_input_model.sv ----
// Behavioural model of the analog voltages seen by the comparator.
`default_nettype none

module analog_input_model #(
    parameter logic [11:0] BANDGAP_MV = 12'h44c,
    parameter logic [11:0] PIN_HIGH_MV = 12'h5dc
) (
    // Controls from the block.
    input  wire logic             power_off,
    input  wire logic             bandgap_select,
    input  wire logic             negative_from_mux,
    input  wire logic [1:0]       negative_channel,
    // Voltages in millivolts.
    input  wire logic [11:0]      positive_mv,
    input  wire logic [11:0]      negative_mv,
    input  wire logic [3:0][11:0] channel_mv,
    // Levels towards the block.
    output logic                  comparator_raw,
    output logic                  positive_pin_level,
    output logic                  negative_pin_level
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [11:0] plus;
    logic [11:0] minus;
    always_comb begin
        plus = bandgap_select ? BANDGAP_MV : positive_mv;
        minus = negative_from_mux ? channel_mv[negative_channel]
                                  : negative_mv;
        comparator_raw = !power_off && (plus > minus);
        positive_pin_level = positive_mv > PIN_HIGH_MV;
        negative_pin_level = negative_mv > PIN_HIGH_MV;
    end
endmodule : analog_input_model

`default_nettype wire

// ---- verif/analog_comparator_control_tb.sv ----
// Self-checking bench of the comparator control block.
`default_nettype none

module analog_comparator_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] CB  = comparator_pkg::CONVERTER_CONTROL_B_ADDR;
    localparam logic [7:0] CTL = comparator_pkg::COMPARATOR_CONTROL_ADDR;
    localparam logic [7:0] DI  = comparator_pkg::DIGITAL_INPUT_OFF_ADDR;
    localparam logic [7:0] ST  = comparator_pkg::EVENT_STATUS_ADDR;
    localparam logic [7:0] CLR = comparator_pkg::EVENT_CLEAR_ADDR;
    localparam logic [7:0] EN  = comparator_pkg::EVENT_ENABLE_ADDR;
    logic clk = 0, reset = 1, avs_read = 0, avs_write = 0;
    logic [7:0] avs_address = 8'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata;
    logic avs_waitrequest, raw, pos_lvl, neg_lvl, pwr_off, bg, from_mux;
    logic [1:0] neg_ch, channel_select = 2'h0;
    logic [5:0] buf_off;
    logic pos_rd, neg_rd, irq_request, irq, converter_enable = 0;
    logic global_irq_enable = 0, irq_vector_taken = 0;
    logic [3:0] be = 4'h1;
    logic [2:0] trig;
    logic [11:0] pos_mv = 12'h000, neg_mv = 12'h3e8;
    logic [3:0][11:0] ch_mv = '0;
    logic [3:0] rows [8] = '{4'b0110, 4'b0100, 4'b1010, 4'b1001,
                             4'b1111, 4'b1100, 4'b0011, 4'b0001};
    int err_total = 0, n_compared = 0, cyc = 0;

    analog_comparator_control dut (.clk(clk), .reset(reset),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(be), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .comparator_raw(raw),
        .positive_pin_level(pos_lvl), .negative_pin_level(neg_lvl),
        .comparator_power_off(pwr_off), .bandgap_select(bg),
        .negative_from_mux(from_mux), .negative_channel(neg_ch),
        .input_buffer_off(buf_off), .positive_pin_read(pos_rd),
        .negative_pin_read(neg_rd), .converter_enable(converter_enable),
        .channel_select(channel_select),
        .global_irq_enable(global_irq_enable),
        .irq_vector_taken(irq_vector_taken),
        .trigger_source_select(trig), .irq_request(irq_request), .irq(irq));
    analog_input_model model (.power_off(pwr_off), .bandgap_select(bg),
        .negative_from_mux(from_mux), .negative_channel(neg_ch),
        .positive_mv(pos_mv), .negative_mv(neg_mv), .channel_mv(ch_mv),
        .comparator_raw(raw), .positive_pin_level(pos_lvl),
        .negative_pin_level(neg_lvl));

    always #20 clk = ~clk;

    task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic bus(logic [7:0] a, logic w, logic [7:0] d,
                       output logic [31:0] q);
        @(posedge clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= {24'h0, d};
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task automatic wr(logic [7:0] a, logic [7:0] d);
        logic [31:0] q;
        bus(a, 1'b1, d, q);
    endtask : wr
    task automatic rd(string nm, logic [7:0] a, logic [7:0] exp);
        logic [31:0] q;
        bus(a, 1'b0, 8'h00, q);
        check(nm, q, {24'h0, exp});
    endtask : rd
    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : stop_test

    // Cuts a hung run short.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_total++;
            stop_test();
        end
    end

    initial begin
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        rd("ctl reset", CTL, 8'h00);
        rd("cb reset", CB, 8'h00);
        rd("di reset", DI, 8'h00);
        for (int i = 0; i < 8; i++) begin
            pos_mv <= rows[i][1] ? 12'h000 : 12'h7d0;
            repeat (4) @(posedge clk);
            wr(CTL, {6'h04, rows[i][3:2]});
            pos_mv <= rows[i][1] ? 12'h7d0 : 12'h000;
            repeat (5) @(posedge clk);
            rd("row ctl", CTL, {2'b00, rows[i][1:0], 2'b00,
                rows[i][3:2]});
        end
        $display("test event rows done");
        global_irq_enable <= 1'b1;
        wr(CTL, 8'h18);
        wr(EN, 8'h03);
        pos_mv <= 12'h7d0;
        repeat (6) @(posedge clk);
        check("irq_request", irq_request, 1);
        check("irq", irq, 1);
        rd("status", ST, 8'h03);
        global_irq_enable <= 1'b0;
        repeat (2) @(posedge clk);
        check("irq_request off", irq_request, 0);
        global_irq_enable <= 1'b1;
        irq_vector_taken <= 1'b1;
        @(posedge clk);
        irq_vector_taken <= 1'b0;
        repeat (2) @(posedge clk);
        check("irq_request taken", irq_request, 0);
        rd("ctl taken", CTL, 8'h28);
        wr(CLR, 8'h03);
        rd("status cleared", ST, 8'h00);
        check("irq cleared", irq, 0);
        pos_mv <= 12'h000;
        repeat (6) @(posedge clk);
        wr(CTL, 8'h08);
        rd("flag kept", CTL, 8'h18);
        wr(CTL, 8'h18);
        rd("flag cleared", CTL, 8'h08);
        $display("test interrupt done");
        wr(CTL, 8'h00);
        wr(CTL, 8'h80);
        wr(CTL, 8'hff);
        rd("ctl all ones", CTL, 8'hcb);
        check("power off", pwr_off, 1);
        check("bandgap", bg, 1);
        wr(CTL, 8'hc3);
        wr(CTL, 8'h40);
        repeat (4) @(posedge clk);
        rd("bandgap result", CTL, 8'h70);
        wr(CTL, 8'h00);
        pos_mv <= 12'h5dc;
        ch_mv[2] <= 12'h7d0;
        channel_select <= 2'h2;
        wr(CB, 8'h47);
        repeat (4) @(posedge clk);
        rd("mux result", CTL, 8'h10);
        rd("cb", CB, 8'h47);
        check("trigger", trig, 3'h7);
        converter_enable <= 1'b1;
        repeat (5) @(posedge clk);
        rd("pin result", CTL, 8'h30);
        $display("test inputs done");
        pos_mv <= 12'h7d0;
        neg_mv <= 12'h708;
        repeat (5) @(posedge clk);
        check("pos read", pos_rd, 1);
        check("neg read", neg_rd, 1);
        wr(DI, 8'h03);
        repeat (3) @(posedge clk);
        check("pos off", pos_rd, 0);
        check("neg off", neg_rd, 0);
        rd("di", DI, 8'h03);
        wr(8'h04, 8'hff);
        rd("unmapped", 8'h04, 8'h00);
        be <= 4'h0;
        wr(DI, 8'h00);
        be <= 4'h1;
        rd("di lane off", DI, 8'h03);
        rd("clear reads zero", CLR, 8'h00);
        $display("test buffers done");
        reset <= 1'b1;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        rd("ctl after reset", CTL, 8'h20);
        rd("di after reset", DI, 8'h00);
        check("irq_request after reset", irq_request, 0);
        $display("test reset done");
        stop_test();
    end
endmodule : analog_comparator_control_tb

`default_nettype wire
